// >>> sdc_entity_field_parser.sv
// entity body parser for region, time, audio and channel parameter entities
//
// Operation
// - region body: id 4, lat 8, lon 9, lat ext 7, lon ext 8, zones; id zero illegal
// - latitude is signed southern edge, legal from -90 to +90
// - longitude is signed western edge, legal from -180 to +179
// - eastern bound may pass +179 and wraps into negative longitudes
// - zero to sixteen zone bytes, each legal from 1 to 85
// - zone count equals header length minus four
// - area and zones together mean the intersection of both
// - time body: 17-bit date, 5-bit hour, 6-bit minute
// - audio body layout from short id down to one reserved bit
// - coding 00 AAC, 01 CELP, 10 HVXC, 11 reserved
// - audio mode meaning depends on coding: stereo mode, crc, rate bits
// - sampling codes 000..011 are 8/12/16/24 kHz, rest reserved
// - coder field: reserved, speech rate index, or header flag plus preset
// - header flag 0 picks predefined extension setup, 1 uses carried header
// - channel body layout: layer, robustness, occupancy ... reserved bits
// - robustness 00..11 maps A..D; interleave flag long 2 s or short 400 ms
// - main modulation four codes; description bit 16-QAM or 4-QAM
// - service count 1011 and 1110 reserved
// - channel entity with length zero and first four bits zero means stop
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/10ps

module sdc_entity_field_parser (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // entity body from demultiplexer, bytes msb-first packed at top
  input wire logic body_valid,
  input wire logic [3:0] body_type,
  input wire logic [6:0] body_len,
  input wire logic [159:0] body_data,
  // decoded results
  output logic fields_valid,
  output logic [3:0] fields_type,
  output logic fields_error,
  output logic stop_notice,
  output sdc_parser_pkg::region_t region_out,
  output sdc_parser_pkg::time_t time_out,
  output sdc_parser_pkg::audio_t audio_out,
  output sdc_parser_pkg::channel_t channel_out
);

  // ---------------------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------------------
  // zone byte range check
  function automatic logic zone_bad(input logic [7:0] z);
    zone_bad = (z < sdc_parser_pkg::ZONE_MIN) || (z > sdc_parser_pkg::ZONE_MAX);
  endfunction

  // signed range check on 10-bit value
  function automatic logic out_of(input logic signed [9:0] v, input int lo, input int hi);
    out_of = (int'(v) < lo) || (int'(v) > hi);
  endfunction

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  logic enable_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic fields_valid_ff;
  logic [3:0] fields_type_ff;
  logic fields_error_ff;
  logic stop_ff;
  logic [15:0] entity_cnt_ff;
  logic [sdc_parser_pkg::ERR_BITS-1:0] err_ff;
  sdc_parser_pkg::region_t region_ff;
  sdc_parser_pkg::time_t time_ff;
  sdc_parser_pkg::audio_t audio_ff;
  sdc_parser_pkg::channel_t channel_ff;
  logic [7:0] zones_ff [sdc_parser_pkg::ZONE_CNT_MAX];

  // ---------------------------------------------------------------------------
  // region decode
  // ---------------------------------------------------------------------------
  sdc_parser_pkg::region_t nxt_region;
  logic [sdc_parser_pkg::ERR_BITS-1:0] reg_err;
  logic signed [9:0] east_raw;
  logic signed [9:0] north_raw;
  logic [6:0] zone_cnt_raw;

  // field extraction, wrap and limits
  always_comb begin
    nxt_region.id = body_data[159:156];
    nxt_region.lat = body_data[155:148];
    nxt_region.lon = body_data[147:139];
    nxt_region.lat_ext = body_data[138:132];
    nxt_region.lon_ext = body_data[131:124];
    zone_cnt_raw = body_len - 7'(sdc_parser_pkg::REGION_FIXED_BYTES);
    nxt_region.zone_cnt = zone_cnt_raw[4:0];
    north_raw = 10'(nxt_region.lat) + 10'(signed'({1'b0, nxt_region.lat_ext}));
    nxt_region.lat_north = north_raw[8:0];
    east_raw = 10'(nxt_region.lon) + 10'(signed'({1'b0, nxt_region.lon_ext}));
    if (int'(east_raw) > sdc_parser_pkg::LON_MAX) begin
      east_raw = east_raw - 10'(sdc_parser_pkg::LON_SPAN);
    end
    nxt_region.lon_east = east_raw[8:0];
    reg_err = '0;
    reg_err[sdc_parser_pkg::ERR_REGION_ID] = (nxt_region.id == 4'h0);
    reg_err[sdc_parser_pkg::ERR_LAT] = out_of(10'(nxt_region.lat), sdc_parser_pkg::LAT_MIN,
                                              sdc_parser_pkg::LAT_MAX);
    reg_err[sdc_parser_pkg::ERR_LON] = out_of(10'(nxt_region.lon), sdc_parser_pkg::LON_MIN,
                                              sdc_parser_pkg::LON_MAX);
    reg_err[sdc_parser_pkg::ERR_LAT_SPAN] = (int'(north_raw) > sdc_parser_pkg::LAT_MAX);
    reg_err[sdc_parser_pkg::ERR_ZONE_CNT] = (body_len < 7'(sdc_parser_pkg::REGION_FIXED_BYTES)) ||
                                            (zone_cnt_raw > 7'(sdc_parser_pkg::ZONE_CNT_MAX));
    for (int i = 0; i < sdc_parser_pkg::ZONE_CNT_MAX; i++) begin
      if ((i < int'(zone_cnt_raw)) && zone_bad(body_data[123-8*i -: 8])) begin
        reg_err[sdc_parser_pkg::ERR_ZONE] = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // time decode
  // ---------------------------------------------------------------------------
  sdc_parser_pkg::time_t nxt_time;

  // date, hour, minute split
  always_comb begin
    nxt_time.mjd = body_data[159:143];
    nxt_time.hour = body_data[142:138];
    nxt_time.minute = body_data[137:132];
  end

  // ---------------------------------------------------------------------------
  // audio decode
  // ---------------------------------------------------------------------------
  sdc_parser_pkg::audio_t nxt_audio;
  logic [sdc_parser_pkg::ERR_BITS-1:0] aud_err;

  // raw fields and coding-dependent meanings
  always_comb begin
    nxt_audio = '0;
    aud_err = '0;
    nxt_audio.short_id = body_data[159:158];
    nxt_audio.stream_id = body_data[157:156];
    nxt_audio.coding = body_data[155:154];
    nxt_audio.sbr = body_data[153];
    nxt_audio.mode = body_data[152:151];
    nxt_audio.rate = body_data[150:148];
    nxt_audio.text = body_data[147];
    nxt_audio.enh = body_data[146];
    nxt_audio.coder = body_data[145:141];
    nxt_audio.rsvd = body_data[140];
    aud_err[sdc_parser_pkg::ERR_RATE] = (nxt_audio.rate > sdc_parser_pkg::RATE_LAST_VALID);
    aud_err[sdc_parser_pkg::ERR_AUDIO_RSVD] = nxt_audio.rsvd;
    unique case (nxt_audio.coding)
      sdc_parser_pkg::CODING_AAC: begin
        aud_err[sdc_parser_pkg::ERR_AUDIO_MODE] = (nxt_audio.mode == sdc_parser_pkg::AAC_MODE_RSVD);
        aud_err[sdc_parser_pkg::ERR_AUDIO_RSVD] = nxt_audio.rsvd || (nxt_audio.coder != 5'h0_0);
      end
      sdc_parser_pkg::CODING_CELP: begin
        nxt_audio.speech_crc_enable = nxt_audio.mode[0];
        nxt_audio.sbr_header_present = nxt_audio.sbr & nxt_audio.mode[1];
        nxt_audio.speech_rate_index = nxt_audio.coder;
        if (!nxt_audio.sbr && nxt_audio.mode[1]) begin
          aud_err[sdc_parser_pkg::ERR_AUDIO_RSVD] = 1'b1;
        end
      end
      sdc_parser_pkg::CODING_HVXC: begin
        nxt_audio.hvxc_rate_4k = nxt_audio.mode[1];
        nxt_audio.speech_crc_enable = nxt_audio.mode[0];
        if (nxt_audio.sbr) begin
          nxt_audio.sbr_header_present = nxt_audio.coder[4];
          nxt_audio.sbr_preset = nxt_audio.coder[4] ? 4'h0 : nxt_audio.coder[3:0];
          if (nxt_audio.coder[4] && (nxt_audio.coder[3:0] != 4'h0)) begin
            aud_err[sdc_parser_pkg::ERR_AUDIO_RSVD] = 1'b1;
          end
        end else if (nxt_audio.coder != 5'h0_0) begin
          aud_err[sdc_parser_pkg::ERR_AUDIO_RSVD] = 1'b1;
        end
      end
      sdc_parser_pkg::CODING_RSVD: begin
        aud_err[sdc_parser_pkg::ERR_CODING] = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // channel parameter decode
  // ---------------------------------------------------------------------------
  sdc_parser_pkg::channel_t nxt_channel;
  logic [sdc_parser_pkg::ERR_BITS-1:0] chan_err;

  // fields, stop notice and reserved codes
  always_comb begin
    nxt_channel.layer = body_data[159];
    nxt_channel.robustness = body_data[158:157];
    nxt_channel.occupancy = body_data[156:153];
    nxt_channel.interleave = body_data[152];
    nxt_channel.main_mod = body_data[151:150];
    nxt_channel.desc_mod = body_data[149];
    nxt_channel.services = body_data[148:145];
    nxt_channel.rsvd = body_data[144:140];
    nxt_channel.stop_notice = (body_len == 7'h0_0) && (body_data[159:156] == 4'h0);
    chan_err = '0;
    chan_err[sdc_parser_pkg::ERR_SERVICES] = !nxt_channel.stop_notice &&
      ((nxt_channel.services == sdc_parser_pkg::SERVICES_RSVD_A) ||
       (nxt_channel.services == sdc_parser_pkg::SERVICES_RSVD_B));
    chan_err[sdc_parser_pkg::ERR_CHAN_RSVD] = !nxt_channel.stop_notice && (nxt_channel.rsvd != 5'h0_0);
  end

  // ---------------------------------------------------------------------------
  // capture of parsed entities
  // ---------------------------------------------------------------------------
  logic accept;
  assign accept = body_valid && enable_ff;

  // result strobe and error summary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fields_valid_ff <= 1'b0;
      fields_type_ff <= 4'h0;
      fields_error_ff <= 1'b0;
      err_ff <= '0;
    end else begin
      fields_valid_ff <= 1'b0;
      if (accept) begin
        fields_valid_ff <= 1'b1;
        fields_type_ff <= body_type;
        unique case (body_type)
          sdc_parser_pkg::ENT_REGION: begin
            err_ff <= reg_err;
            fields_error_ff <= |reg_err;
          end
          sdc_parser_pkg::ENT_AUDIO: begin
            err_ff <= aud_err;
            fields_error_ff <= |aud_err;
          end
          sdc_parser_pkg::ENT_CHANNEL: begin
            err_ff <= chan_err;
            fields_error_ff <= |chan_err;
          end
          default: begin
            err_ff <= '0;
            fields_error_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // per-entity field holding; zones kept for intersection downstream
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      region_ff <= '0;
      time_ff <= '0;
      audio_ff <= '0;
      channel_ff <= '0;
      stop_ff <= 1'b0;
      for (int i = 0; i < sdc_parser_pkg::ZONE_CNT_MAX; i++) begin
        zones_ff[i] <= 8'h00;
      end
    end else if (accept) begin
      if (body_type == sdc_parser_pkg::ENT_REGION) begin
        region_ff <= nxt_region;
        for (int i = 0; i < sdc_parser_pkg::ZONE_CNT_MAX; i++) begin
          // unused slots zero so downstream treats them as absent
          zones_ff[i] <= (i < int'(nxt_region.zone_cnt)) ? body_data[123-8*i -: 8] : 8'h00;
        end
      end
      if (body_type == sdc_parser_pkg::ENT_TIME) begin
        time_ff <= nxt_time;
      end
      if (body_type == sdc_parser_pkg::ENT_AUDIO) begin
        audio_ff <= nxt_audio;
      end
      if (body_type == sdc_parser_pkg::ENT_CHANNEL) begin
        channel_ff <= nxt_channel;
        stop_ff <= nxt_channel.stop_notice;
      end
    end
  end

  // count of accepted entities
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      entity_cnt_ff <= 16'h0000;
    end else if (accept) begin
      entity_cnt_ff <= entity_cnt_ff + 16'h0001;
    end
  end

  // ---------------------------------------------------------------------------
  // apb slave: one wait-free access phase
  // ---------------------------------------------------------------------------
  logic [31:0] rd_mux;
  logic addr_ok;
  logic [3:0] zone_idx;
  assign zone_idx = paddr[5:2];

  // read mux and decode
  always_comb begin
    rd_mux = 32'h0000_0000;
    addr_ok = 1'b1;
    if (paddr >= sdc_parser_pkg::REG_ZONES) begin
      addr_ok = (paddr[1:0] == 2'h0) && (paddr < sdc_parser_pkg::REG_ZONES + 8'h40);
      rd_mux = {24'h00_0000, zones_ff[zone_idx - 4'h8]};
    end else begin
      unique case (paddr)
        sdc_parser_pkg::REG_CTRL: rd_mux = {31'h0000_0000, enable_ff};
        sdc_parser_pkg::REG_STATUS: rd_mux = {entity_cnt_ff, 10'h000, stop_ff, fields_error_ff, fields_type_ff};
        sdc_parser_pkg::REG_REGION0: rd_mux = {region_ff.id, region_ff.lat, region_ff.lon,
                                               region_ff.lat_ext, region_ff.zone_cnt[3:0]};
        sdc_parser_pkg::REG_REGION1: rd_mux = {6'h00, region_ff.zone_cnt, region_ff.lon_ext,
                                               region_ff.lon_east, region_ff.lat_north[3:0]};
        sdc_parser_pkg::REG_TIME: rd_mux = {4'h0, time_ff};
        sdc_parser_pkg::REG_AUDIO: rd_mux = {12'h000, audio_ff.short_id, audio_ff.stream_id, audio_ff.coding,
                                             audio_ff.sbr, audio_ff.mode, audio_ff.rate, audio_ff.text,
                                             audio_ff.enh, audio_ff.coder, audio_ff.rsvd};
        sdc_parser_pkg::REG_CHANNEL: rd_mux = {11'h000, channel_ff};
        sdc_parser_pkg::REG_ERRORS: rd_mux = {20'h0_0000, err_ff};
        default: addr_ok = 1'b0;
      endcase
    end
  end

  // ready, error and read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= psel && !penable;
      pslverr_ff <= psel && !penable && !addr_ok;
      prdata_ff <= (psel && !penable && !pwrite && addr_ok) ? rd_mux : 32'h0000_0000;
    end
  end

  // control register write at end of access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_ff <= sdc_parser_pkg::CTRL_RESET[0];
    end else if (psel && penable && pready_ff && pwrite && (paddr == sdc_parser_pkg::REG_CTRL)) begin
      enable_ff <= pwdata[0];
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign fields_valid = fields_valid_ff;
  assign fields_type = fields_type_ff;
  assign fields_error = fields_error_ff;
  assign stop_notice = stop_ff;
  assign region_out = region_ff;
  assign time_out = time_ff;
  assign audio_out = audio_ff;
  assign channel_out = channel_ff;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  region_id_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && body_type == sdc_parser_pkg::ENT_REGION && body_data[159:156] == 4'h0 |=> fields_error)
    else $error("zero region id not flagged");

  lat_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && body_type == sdc_parser_pkg::ENT_REGION && $signed(body_data[155:148]) > 8'sd90
    |=> err_ff[sdc_parser_pkg::ERR_LAT])
    else $error("latitude above limit not flagged");

  lon_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && body_type == sdc_parser_pkg::ENT_REGION && $signed(body_data[147:139]) < -9'sd180
    |=> err_ff[sdc_parser_pkg::ERR_LON])
    else $error("longitude below limit not flagged");

  east_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    fields_valid && fields_type == sdc_parser_pkg::ENT_REGION |->
    (region_out.lon_east >= -9'sd180 && region_out.lon_east <= 9'sd179 || region_out.lon > 9'sd179 ||
     region_out.lon < -9'sd180))
    else $error("eastern bound not wrapped");

  zone_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && body_type == sdc_parser_pkg::ENT_REGION |=> region_out.zone_cnt == 5'($past(body_len) - 7'd4))
    else $error("zone count wrong");

  time_split_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && body_type == sdc_parser_pkg::ENT_TIME |=> time_out.minute == $past(body_data[137:132]))
    else $error("minute field wrong");

  coding_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && body_type == sdc_parser_pkg::ENT_AUDIO && body_data[155:154] == 2'h3 |=> fields_error)
    else $error("reserved coding not flagged");

  rate_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && body_type == sdc_parser_pkg::ENT_AUDIO && body_data[150] |=> err_ff[sdc_parser_pkg::ERR_RATE])
    else $error("reserved rate not flagged");

  stop_detect_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && body_type == sdc_parser_pkg::ENT_CHANNEL && body_len == 7'd0 && body_data[159:156] == 4'h0
    |=> stop_notice)
    else $error("stop notice missed");

  services_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && body_type == sdc_parser_pkg::ENT_CHANNEL && body_len != 7'd0 && body_data[148:145] == 4'hb
    |=> fields_error)
    else $error("reserved service code not flagged");

endmodule

// >>> sdc_parser_pkg.sv
// package: constants, types and field layouts for the entity parser
package sdc_parser_pkg;

  // ---------------------------------------------------------------------------
  // entity types handled
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ENT_REGION = 4'h7;
  localparam logic [3:0] ENT_TIME = 4'h8;
  localparam logic [3:0] ENT_AUDIO = 4'h9;
  localparam logic [3:0] ENT_CHANNEL = 4'ha;

  // ---------------------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_REGION0 = 8'h08;
  localparam logic [7:0] REG_REGION1 = 8'h0c;
  localparam logic [7:0] REG_TIME = 8'h10;
  localparam logic [7:0] REG_AUDIO = 8'h14;
  localparam logic [7:0] REG_CHANNEL = 8'h18;
  localparam logic [7:0] REG_ERRORS = 8'h1c;
  localparam logic [7:0] REG_ZONES = 8'h20;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // ---------------------------------------------------------------------------
  // limits
  // ---------------------------------------------------------------------------
  localparam int LAT_MIN = -90;
  localparam int LAT_MAX = 90;
  localparam int LON_MIN = -180;
  localparam int LON_MAX = 179;
  localparam int LON_SPAN = 360;
  localparam logic [7:0] ZONE_MIN = 8'h01;
  localparam logic [7:0] ZONE_MAX = 8'h55;
  localparam int ZONE_CNT_MAX = 16;
  localparam int REGION_FIXED_BYTES = 4;
  localparam int BODY_BYTES = 20;

  // ---------------------------------------------------------------------------
  // codes
  // ---------------------------------------------------------------------------
  localparam logic [1:0] CODING_AAC = 2'h0;
  localparam logic [1:0] CODING_CELP = 2'h1;
  localparam logic [1:0] CODING_HVXC = 2'h2;
  localparam logic [1:0] CODING_RSVD = 2'h3;
  localparam logic [1:0] AAC_MODE_RSVD = 2'h3;
  localparam logic [2:0] RATE_LAST_VALID = 3'h3;
  localparam logic [3:0] SERVICES_RSVD_A = 4'hb;
  localparam logic [3:0] SERVICES_RSVD_B = 4'he;

  // error bit positions
  localparam int ERR_REGION_ID = 0;
  localparam int ERR_LAT = 1;
  localparam int ERR_LON = 2;
  localparam int ERR_LAT_SPAN = 3;
  localparam int ERR_ZONE = 4;
  localparam int ERR_ZONE_CNT = 5;
  localparam int ERR_CODING = 6;
  localparam int ERR_AUDIO_MODE = 7;
  localparam int ERR_RATE = 8;
  localparam int ERR_AUDIO_RSVD = 9;
  localparam int ERR_SERVICES = 10;
  localparam int ERR_CHAN_RSVD = 11;
  localparam int ERR_BITS = 12;

  typedef enum logic [1:0] {
    IL_LONG,
    IL_SHORT
  } interleave_t;

  typedef struct packed {
    logic [3:0] id;
    logic signed [7:0] lat;
    logic signed [8:0] lon;
    logic [6:0] lat_ext;
    logic [7:0] lon_ext;
    logic signed [8:0] lon_east;
    logic signed [8:0] lat_north;
    logic [4:0] zone_cnt;
  } region_t;

  typedef struct packed {
    logic [16:0] mjd;
    logic [4:0] hour;
    logic [5:0] minute;
  } time_t;

  typedef struct packed {
    logic [1:0] short_id;
    logic [1:0] stream_id;
    logic [1:0] coding;
    logic sbr;
    logic [1:0] mode;
    logic [2:0] rate;
    logic text;
    logic enh;
    logic [4:0] coder;
    logic rsvd;
    logic speech_crc_enable;
    logic hvxc_rate_4k;
    logic sbr_header_present;
    logic [4:0] speech_rate_index;
    logic [3:0] sbr_preset;
  } audio_t;

  typedef struct packed {
    logic layer;
    logic [1:0] robustness;
    logic [3:0] occupancy;
    logic interleave;
    logic [1:0] main_mod;
    logic desc_mod;
    logic [3:0] services;
    logic [4:0] rsvd;
    logic stop_notice;
  } channel_t;

endpackage

// >>> body_source.sv
// demultiplexer model offering entity bodies
`timescale 1ns/10ps
module body_source (
  // clock and bench request
  input wire logic pclk,
  input wire logic send,
  input wire logic [3:0] typ,
  input wire logic [6:0] len,
  input wire logic [159:0] data,
  // body towards the parser
  output logic body_valid,
  output logic [3:0] body_type,
  output logic [6:0] body_len,
  output logic [159:0] body_data
);
  // one-cycle offer; fields inverted while idle so stale bytes never look valid
  always_ff @(posedge pclk) begin
    body_valid <= send;
    body_type <= send ? typ : ~body_type;
    body_len <= send ? len : ~body_len;
    body_data <= send ? data : ~body_data;
  end
endmodule

// >>> sdc_entity_field_parser_tb.sv
// self-checking bench for the entity field parser
`timescale 1ns/10ps
module sdc_entity_field_parser_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, send, body_valid;
  logic fields_valid, fields_error, stop_notice, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] typ, body_type, fields_type;
  logic [6:0] len, body_len;
  logic [159:0] data, body_data, b;
  logic [13:0] x, exp_q[$];
  sdc_parser_pkg::region_t region_out;
  sdc_parser_pkg::time_t time_out;
  sdc_parser_pkg::audio_t audio_out;
  sdc_parser_pkg::channel_t channel_out;
  int n_errors, samples_checked, i, j, lat, lon, east;
  body_source i_body_source (.pclk, .send, .typ, .len, .data, .body_valid, .body_type, .body_len, .body_data);
  sdc_entity_field_parser i_sdc_entity_field_parser (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .body_valid, .body_type, .body_len, .body_data, .fields_valid, .fields_type,
    .fields_error, .stop_notice, .region_out, .time_out, .audio_out, .channel_out);
  // -------------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------------
  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    samples_checked++;
    if (got !== ex) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (k = 0; k < 50; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 50) begin
      n_errors++;
      report_and_stop();
    end
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic send_body(input logic [3:0] t, input logic [6:0] l, input logic [159:0] d, input logic er,
    input logic [8:0] k);
    @(posedge pclk);
    send <= 1;
    typ <= t;
    len <= l;
    data <= d;
    exp_q.push_back({t, er, k});
    @(posedge pclk);
    send <= 0;
  endtask
  task automatic region(input logic [159:0] d, input int n);
    logic er;
    lat = $signed(d[155:148]);
    lon = $signed(d[147:139]);
    east = lon + int'(d[131:124]);
    er = d[159:156] == 0 || lat > 90 || lat < -90 || lon > 179 || lon < -180 || lat + int'(d[138:132]) > 90;
    for (j = 0; j < n; j++) er |= d[123-8*j -: 8] == 0 || d[123-8*j -: 8] > 85;
    send_body(sdc_parser_pkg::ENT_REGION, 7'(4 + n), d, er, 9'(east > 179 ? east - 360 : east));
  endtask
  // watcher: each result takes the oldest note
  always @(negedge pclk) begin
    if (fields_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("spurious", 0, 1);
      end else begin
        x = exp_q.pop_front();
        chk("type", x[13:10], fields_type);
        chk("error", x[9], fields_error);
        chk("key", x[8:0], x[13:10] == 7 ? region_out.lon_east : x[13:10] == 8 ? time_out.minute :
          x[13:10] == 9 ? audio_out.coding : {channel_out.services, stop_notice});
      end
    end
  end
  // -------------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, send, typ, len, data} = '0;
    void'($urandom(32'h722d4c44));
    repeat (4) @(posedge pclk);
    presetn <= 1;
    apb(0, sdc_parser_pkg::REG_CTRL, 0);
    chk("ctrl", sdc_parser_pkg::CTRL_RESET, r);
    apb(0, 8'h60, 0);
    chk("slverr", 1, e);
    $display("register tests done");
    region({4'h3, 8'hf6, 9'h0aa, 7'h14, 8'h1e, 8'h01, 8'h55, 108'h0}, 2);
    for (i = 0; i < 20; i++) begin
      b = {$urandom, $urandom, $urandom, $urandom, $urandom};
      if (i == 0) b[159:156] = 4'h0;
      region(b, $urandom % 17);
      send_body(sdc_parser_pkg::ENT_TIME, 7'h4, b, 1'b0, {3'h0, b[137:132]});
    end
    $display("region and time done");
    for (i = 0; i < 4; i++) begin
      r = $urandom;
      send_body(sdc_parser_pkg::ENT_AUDIO, 7'h3, {4'h6, 2'(i), 3'h0, r[2:0], 8'h0, 140'h0},
        i == 3 || r[2:0] > 3, 9'(i));
    end
    for (i = 0; i < 16; i++) begin
      send_body(sdc_parser_pkg::ENT_CHANNEL, 7'h3, {11'h1c1, 4'(i), 145'h0}, i == 11 || i == 14,
        9'({4'(i), 1'b0}));
    end
    send_body(sdc_parser_pkg::ENT_CHANNEL, 7'h0, 160'h0, 1'b0, 9'h1);
    $display("audio and channel done");
    apb(1, sdc_parser_pkg::REG_CTRL, 0);
    send_body(sdc_parser_pkg::ENT_TIME, 7'h4, b, 1'b0, 9'h0);
    void'(exp_q.pop_back());
    repeat (5) @(posedge pclk);
    chk("drain", 0, exp_q.size());
    apb(0, sdc_parser_pkg::REG_STATUS, 0);
    chk("status", 32'h003e_002a, r);
    $display("disable and status done");
    report_and_stop();
  end
endmodule
